// *** rtl/mlr_pkg.sv ***
// Constants, opcodes and register map of the move, logic and rotate datapath
package mlr_pkg;

  localparam int DATA_W    = 8;
  localparam int FLAG_W    = 6;
  localparam int APB_AW    = 12;
  localparam int APB_DW    = 32;
  localparam int PC_W_DEF  = 11;
  localparam int MADDR_DEF = 8;

  // APB register byte addresses
  localparam logic [APB_AW-1:0] OFS_WORKING_REG = 12'h000;
  localparam logic [APB_AW-1:0] OFS_STATUS      = 12'h004;
  localparam logic [APB_AW-1:0] OFS_PC          = 12'h008;
  localparam logic [APB_AW-1:0] OFS_CONTROL     = 12'h00C;

  // Status word bit positions, and the enable bit of the control word
  localparam int CARRY_BIT     = 0;
  localparam int HALF_BIT      = 1;
  localparam int ZERO_BIT      = 2;
  localparam int OVERFLOW_BIT  = 3;
  localparam int POWERDOWN_BIT = 4;
  localparam int WDT_BIT       = 5;
  localparam int GIE_BIT       = 0;

  // Reset values
  localparam logic [DATA_W-1:0] WREG_RST  = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
  localparam logic              GIE_RST   = 1'b0;

  // Program counter steps: one per instruction, two across a skip
  localparam int PC_STEP = 1;
  localparam int PC_SKIP = 2;

  typedef enum logic [4:0] {
    OP_MOV_FROM_MEM,
    OP_MOV_IMM,
    OP_MOV_TO_MEM,
    OP_NOP,
    OP_OR_MEM,
    OP_OR_IMM,
    OP_OR_INTO_MEMORY,
    OP_RETURN,
    OP_RETURN_IMM,
    OP_RETURN_FROM_IRQ,
    OP_ROT_LEFT_MEM,
    OP_ROT_LEFT_WREG,
    OP_ROTATE_LEFT_THRU_CARRY,
    OP_ROTATE_LEFT_THRU_CARRY_WREG,
    OP_ROT_RIGHT_MEM,
    OP_ROT_RIGHT_WREG,
    OP_ROTATE_RIGHT_THRU_CARRY,
    OP_ROTATE_RIGHT_THRU_CARRY_WREG,
    OP_SUBTRACT_WITH_BORROW,
    OP_SUBTRACT_WITH_BORROW_MEM,
    OP_DECREMENT_SKIP_IF_ZERO,
    OP_DECREMENT_TO_WREG_SKIP_ZERO
  } mlr_op_type;

endpackage : mlr_pkg

// *** rtl/mlr_exec.sv ***
// Execution datapath for moves, OR, returns, rotates, borrow subtract, skips
//
// Functional notes
// - Memory move loads working_reg from the memory byte, flags kept.
// - Immediate move loads working_reg with its constant, flags kept.
// - Working-to-memory move writes working_reg to memory, flags kept.
// - No-operation only advances program counter by one.
// - OR into working_reg with memory or immediate byte, zero flag only.
// - OR into memory writes working_reg OR byte back, zero flag only.
// - Return pops program counter, takes two cycles, no flag change.
// - Return with constant pops counter and loads working_reg immediate.
// - Interrupt return pops counter and sets global interrupt enable.
// - Rotate left memory, bit 7 into bit 0, written back, no flags.
// - Rotate left into working_reg, memory unchanged, no flags.
// - Nine-bit left rotate through carry on memory, only carry altered.
// - Nine-bit left carry rotate into working_reg, memory unchanged.
// - Rotate right memory, bit 0 into bit 7, written back, no flags.
// - Rotate right into working_reg, memory unchanged, no flags.
// - Right rotate through carry on memory, only carry altered.
// - Right carry rotate into working_reg, memory intact, carry only.
// - working_reg + ~byte + carry kept in working_reg, four flags.
// - Same borrow subtract written to memory, four flags updated.
// - Decrement memory; zero drops the prefetch, two cycles, no flags.
// - Decrement into working_reg, memory unchanged, skip on zero.
// - Six-flag status word; each instruction touches only its own flags, but an OR form puts back the old other five over a same-cycle status write.
`timescale 1ns/100ps

module mlr_exec #(
  parameter int PC_W   = mlr_pkg::PC_W_DEF,
  parameter int MADDR_W = mlr_pkg::MADDR_DEF
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [mlr_pkg::APB_AW-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [mlr_pkg::APB_DW-1:0]  pwdata,
  output      logic                        pready,
  output      logic [mlr_pkg::APB_DW-1:0]  prdata,
  output      logic                        pslverr,
  input  wire logic                        issue_valid,
  input  wire mlr_pkg::mlr_op_type         issue_op,
  input  wire logic [mlr_pkg::DATA_W-1:0]  issue_imm,
  input  wire logic [MADDR_W-1:0]          issue_addr,
  input  wire logic [mlr_pkg::DATA_W-1:0]  mem_rdata,
  output      logic                        issue_ready,
  output      logic                        mem_we,
  output      logic [MADDR_W-1:0]          mem_waddr,
  output      logic [mlr_pkg::DATA_W-1:0]  mem_wdata,
  output      logic                        stack_pop,
  input  wire logic [PC_W-1:0]             stack_pc,
  output      logic [PC_W-1:0]             pc,
  output      logic                        skip_flush,
  output      logic [mlr_pkg::DATA_W-1:0]  working_reg,
  output      logic [mlr_pkg::FLAG_W-1:0]  status_flags,
  output      logic                        global_irq_enable
);

  typedef enum logic {PH_EXEC, PH_DUMMY} mlr_phase_type;

  typedef struct packed {
    mlr_phase_type               phase;
    logic [mlr_pkg::DATA_W-1:0]  wreg;
    logic [mlr_pkg::FLAG_W-1:0]  flags;
    logic                        gie;
    logic [PC_W-1:0]             pc;
    logic                        mem_we;
    logic [MADDR_W-1:0]          mem_waddr;
    logic [mlr_pkg::DATA_W-1:0]  mem_wdata;
    logic                        stack_pop;
    logic                        skip_flush;
    logic [mlr_pkg::APB_DW-1:0]  prdata;
    logic                        pslverr;
  } mlr_state_type;

  mlr_state_type s;
  mlr_state_type next_s;

  // Rotate left with a bit fed in at bit 0; returns {bit out, byte}
  function automatic logic [mlr_pkg::DATA_W:0] rot_left(
    input logic [mlr_pkg::DATA_W-1:0] v,
    input logic                       fill
  );
    rot_left = {v, fill};
  endfunction : rot_left

  // Rotate right with a bit fed in at bit 7; returns {bit out, byte}
  function automatic logic [mlr_pkg::DATA_W:0] rot_right(
    input logic [mlr_pkg::DATA_W-1:0] v,
    input logic                       fill
  );
    rot_right = {v[0], fill, v[mlr_pkg::DATA_W-1:1]};
  endfunction : rot_right

  // a + ~b + cin; returns {overflow, half carry, carry, byte}
  function automatic logic [mlr_pkg::DATA_W+2:0] sub_borrow(
    input logic [mlr_pkg::DATA_W-1:0] a,
    input logic [mlr_pkg::DATA_W-1:0] b,
    input logic                       cin
  );
    logic [4:0]                 lo;
    logic [mlr_pkg::DATA_W-1:0] nb;
    logic [mlr_pkg::DATA_W:0]   full;
    logic [mlr_pkg::DATA_W-1:0] low7;
    logic                       c6;
    nb   = ~b;
    lo   = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, nb} + {8'h00, cin};
    low7 = {1'b0, a[6:0]} + {1'b0, nb[6:0]} + {7'h00, cin};
    c6   = low7[7];
    sub_borrow = {c6 ^ full[8], lo[4], full[8], full[7:0]};
  endfunction : sub_borrow

  // Zero-flag update helper, used by every OR form
  function automatic logic [mlr_pkg::FLAG_W-1:0] with_zero(
    input logic [mlr_pkg::FLAG_W-1:0] f,
    input logic [mlr_pkg::DATA_W-1:0] r
  );
    with_zero = f;
    with_zero[mlr_pkg::ZERO_BIT] = (r == 8'h00);
  endfunction : with_zero

  logic                       accept;
  logic                       apb_setup;
  logic                       apb_write;
  logic                       carry_in;
  logic [mlr_pkg::DATA_W:0]   rl_plain;
  logic [mlr_pkg::DATA_W:0]   rl_carry;
  logic [mlr_pkg::DATA_W:0]   rr_plain;
  logic [mlr_pkg::DATA_W:0]   rr_carry;
  logic [mlr_pkg::DATA_W+2:0] diff_res;
  logic [mlr_pkg::DATA_W-1:0] dec_res;
  logic [mlr_pkg::DATA_W-1:0] or_mem;
  logic [mlr_pkg::DATA_W-1:0] or_imm;

  // Issue is refused during the dummy cycle of a return or a skip
  assign issue_ready = (s.phase == PH_EXEC);
  assign accept      = issue_valid && issue_ready;
  assign apb_setup   = psel && !penable;
  assign apb_write   = psel && penable && pwrite;
  assign carry_in    = s.flags[mlr_pkg::CARRY_BIT];

  assign rl_plain = rot_left(mem_rdata, mem_rdata[mlr_pkg::DATA_W-1]);
  assign rl_carry = rot_left(mem_rdata, carry_in);
  assign rr_plain = rot_right(mem_rdata, mem_rdata[0]);
  assign rr_carry = rot_right(mem_rdata, carry_in);
  assign diff_res = sub_borrow(s.wreg, mem_rdata, carry_in);
  assign dec_res  = mem_rdata - 8'h01;
  assign or_mem   = s.wreg | mem_rdata;
  assign or_imm   = s.wreg | issue_imm;

  always_comb begin
    next_s            = s;
    next_s.mem_we     = 1'b0;
    next_s.stack_pop  = 1'b0;
    next_s.skip_flush = 1'b0;

    // Read data is captured in the setup phase so the access phase needs
    // no wait state and prdata comes straight from a flip-flop.
    if (apb_setup) begin
      next_s.pslverr = 1'b0;
      unique case (paddr)
        mlr_pkg::OFS_WORKING_REG: next_s.prdata = {24'h000000, s.wreg};
        mlr_pkg::OFS_STATUS:      next_s.prdata = {26'h0000000, s.flags};
        mlr_pkg::OFS_PC:
          next_s.prdata = mlr_pkg::APB_DW'(s.pc);
        mlr_pkg::OFS_CONTROL:     next_s.prdata = {31'h00000000, s.gie};
        default: begin
          next_s.prdata  = 32'h00000000;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    // Software writes land first; an instruction in the same cycle wins.
    if (apb_write) begin
      unique case (paddr)
        mlr_pkg::OFS_WORKING_REG: next_s.wreg = pwdata[mlr_pkg::DATA_W-1:0];
        mlr_pkg::OFS_STATUS:      next_s.flags = pwdata[mlr_pkg::FLAG_W-1:0];
        mlr_pkg::OFS_CONTROL:     next_s.gie = pwdata[mlr_pkg::GIE_BIT];
        default: ;
      endcase
    end

    if (s.phase == PH_DUMMY) begin
      next_s.phase = PH_EXEC;
    end else if (accept) begin
      next_s.pc        = s.pc + PC_W'(mlr_pkg::PC_STEP);
      next_s.mem_waddr = issue_addr;
      unique case (issue_op)
        mlr_pkg::OP_MOV_FROM_MEM: next_s.wreg = mem_rdata;
        mlr_pkg::OP_MOV_IMM:      next_s.wreg = issue_imm;
        mlr_pkg::OP_MOV_TO_MEM: begin
          next_s.mem_we    = 1'b1;
          next_s.mem_wdata = s.wreg;
        end
        mlr_pkg::OP_NOP: ;
        mlr_pkg::OP_OR_MEM: begin
          next_s.wreg  = or_mem;
          next_s.flags = with_zero(s.flags, or_mem);
        end
        mlr_pkg::OP_OR_IMM: begin
          next_s.wreg  = or_imm;
          next_s.flags = with_zero(s.flags, or_imm);
        end
        mlr_pkg::OP_OR_INTO_MEMORY: begin
          next_s.mem_we    = 1'b1;
          next_s.mem_wdata = or_mem;
          next_s.flags     = with_zero(s.flags, or_mem);
        end
        mlr_pkg::OP_RETURN: begin
          // Popped address is fetched afresh, so one dummy cycle follows
          next_s.pc        = stack_pc;
          next_s.stack_pop = 1'b1;
          next_s.phase     = PH_DUMMY;
        end
        mlr_pkg::OP_RETURN_IMM: begin
          next_s.pc        = stack_pc;
          next_s.stack_pop = 1'b1;
          next_s.phase     = PH_DUMMY;
          next_s.wreg      = issue_imm;
        end
        mlr_pkg::OP_RETURN_FROM_IRQ: begin
          next_s.pc        = stack_pc;
          next_s.stack_pop = 1'b1;
          next_s.phase     = PH_DUMMY;
          next_s.gie       = 1'b1;
        end
        mlr_pkg::OP_ROT_LEFT_MEM: begin
          next_s.mem_we    = 1'b1;
          next_s.mem_wdata = rl_plain[mlr_pkg::DATA_W-1:0];
        end
        mlr_pkg::OP_ROT_LEFT_WREG:
          next_s.wreg = rl_plain[mlr_pkg::DATA_W-1:0];
        mlr_pkg::OP_ROTATE_LEFT_THRU_CARRY: begin
          next_s.mem_we    = 1'b1;
          next_s.mem_wdata = rl_carry[mlr_pkg::DATA_W-1:0];
          next_s.flags[mlr_pkg::CARRY_BIT] = rl_carry[mlr_pkg::DATA_W];
        end
        mlr_pkg::OP_ROTATE_LEFT_THRU_CARRY_WREG: begin
          next_s.wreg = rl_carry[mlr_pkg::DATA_W-1:0];
          next_s.flags[mlr_pkg::CARRY_BIT] = rl_carry[mlr_pkg::DATA_W];
        end
        mlr_pkg::OP_ROT_RIGHT_MEM: begin
          next_s.mem_we    = 1'b1;
          next_s.mem_wdata = rr_plain[mlr_pkg::DATA_W-1:0];
        end
        mlr_pkg::OP_ROT_RIGHT_WREG:
          next_s.wreg = rr_plain[mlr_pkg::DATA_W-1:0];
        mlr_pkg::OP_ROTATE_RIGHT_THRU_CARRY: begin
          next_s.mem_we    = 1'b1;
          next_s.mem_wdata = rr_carry[mlr_pkg::DATA_W-1:0];
          next_s.flags[mlr_pkg::CARRY_BIT] = rr_carry[mlr_pkg::DATA_W];
        end
        mlr_pkg::OP_ROTATE_RIGHT_THRU_CARRY_WREG: begin
          next_s.wreg = rr_carry[mlr_pkg::DATA_W-1:0];
          next_s.flags[mlr_pkg::CARRY_BIT] = rr_carry[mlr_pkg::DATA_W];
        end
        mlr_pkg::OP_SUBTRACT_WITH_BORROW,
        mlr_pkg::OP_SUBTRACT_WITH_BORROW_MEM: begin
          if (issue_op == mlr_pkg::OP_SUBTRACT_WITH_BORROW) begin
            next_s.wreg = diff_res[mlr_pkg::DATA_W-1:0];
          end else begin
            next_s.mem_we    = 1'b1;
            next_s.mem_wdata = diff_res[mlr_pkg::DATA_W-1:0];
          end
          next_s.flags[mlr_pkg::CARRY_BIT]    = diff_res[mlr_pkg::DATA_W];
          next_s.flags[mlr_pkg::HALF_BIT]     = diff_res[mlr_pkg::DATA_W+1];
          next_s.flags[mlr_pkg::OVERFLOW_BIT] = diff_res[mlr_pkg::DATA_W+2];
          next_s.flags[mlr_pkg::ZERO_BIT] =
            (diff_res[mlr_pkg::DATA_W-1:0] == 8'h00);
        end
        mlr_pkg::OP_DECREMENT_SKIP_IF_ZERO,
        mlr_pkg::OP_DECREMENT_TO_WREG_SKIP_ZERO: begin
          if (issue_op == mlr_pkg::OP_DECREMENT_SKIP_IF_ZERO) begin
            next_s.mem_we    = 1'b1;
            next_s.mem_wdata = dec_res;
          end else begin
            next_s.wreg = dec_res;
          end
          // The prefetched word is dropped and replaced by a dummy cycle
          if (dec_res == 8'h00) begin
            next_s.pc         = s.pc + PC_W'(mlr_pkg::PC_SKIP);
            next_s.skip_flush = 1'b1;
            next_s.phase      = PH_DUMMY;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.phase      <= PH_EXEC;
      s.wreg       <= mlr_pkg::WREG_RST;
      s.flags      <= mlr_pkg::FLAGS_RST;
      s.gie        <= mlr_pkg::GIE_RST;
      s.pc         <= '0;
      s.mem_we     <= 1'b0;
      s.mem_waddr  <= '0;
      s.mem_wdata  <= 8'h00;
      s.stack_pop  <= 1'b0;
      s.skip_flush <= 1'b0;
      s.prdata     <= 32'h00000000;
      s.pslverr    <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign pready            = 1'b1;
  assign prdata            = s.prdata;
  assign pslverr           = s.pslverr;
  assign mem_we            = s.mem_we;
  assign mem_waddr         = s.mem_waddr;
  assign mem_wdata         = s.mem_wdata;
  assign stack_pop         = s.stack_pop;
  assign pc                = s.pc;
  assign skip_flush        = s.skip_flush;
  assign working_reg       = s.wreg;
  assign status_flags      = s.flags;
  assign global_irq_enable = s.gie;

  mov_mem_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && issue_op == mlr_pkg::OP_MOV_FROM_MEM && !apb_write
    |=> working_reg == $past(mem_rdata) && status_flags == $past(status_flags)
        && !mem_we)
    else $error("move from memory wrong");

  mov_imm_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && issue_op == mlr_pkg::OP_MOV_IMM
    |=> working_reg == $past(issue_imm))
    else $error("immediate move wrong");

  wr_mem_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && issue_op == mlr_pkg::OP_MOV_TO_MEM
    |=> mem_we && mem_wdata == $past(working_reg)
        && mem_waddr == $past(issue_addr)
        ##1 (!mem_we || $past(accept)))
    else $error("store to memory wrong");

  nop_pc_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && issue_op == mlr_pkg::OP_NOP
    |=> pc == $past(pc) + PC_W'(1) && !mem_we && issue_ready)
    else $error("no-operation step wrong");

  or_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && issue_op == mlr_pkg::OP_OR_INTO_MEMORY && !apb_write
    |=> mem_wdata == ($past(working_reg) | $past(mem_rdata))
        && status_flags[mlr_pkg::ZERO_BIT] == (mem_wdata == 8'h00))
    else $error("or into memory wrong");

  ret_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && issue_op inside {mlr_pkg::OP_RETURN, mlr_pkg::OP_RETURN_IMM,
                               mlr_pkg::OP_RETURN_FROM_IRQ}
    |=> stack_pop && !issue_ready && pc == $past(stack_pc) ##1 issue_ready)
    else $error("return timing wrong");

  irq_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && issue_op == mlr_pkg::OP_RETURN_FROM_IRQ |=> global_irq_enable)
    else $error("interrupt enable not set");

  cy_left_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && issue_op == mlr_pkg::OP_ROTATE_LEFT_THRU_CARRY && !apb_write
    |=> status_flags[mlr_pkg::CARRY_BIT] == $past(mem_rdata[7])
        && mem_wdata[0] == $past(status_flags[mlr_pkg::CARRY_BIT]))
    else $error("left carry rotate wrong");

  rr_wreg_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && issue_op == mlr_pkg::OP_ROT_RIGHT_WREG && !apb_write
    |=> working_reg == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}
        && !mem_we)
    else $error("right rotate to working wrong");

  sub_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && issue_op == mlr_pkg::OP_SUBTRACT_WITH_BORROW && !apb_write
    |=> {status_flags[mlr_pkg::CARRY_BIT], working_reg} ==
        9'($past({1'b0, working_reg}) + $past({1'b0, ~mem_rdata})
           + $past(9'(status_flags[mlr_pkg::CARRY_BIT]))))
    else $error("borrow subtract wrong");

  skip_pc_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && issue_op == mlr_pkg::OP_DECREMENT_SKIP_IF_ZERO
           && mem_rdata == 8'h01
    |=> skip_flush && !issue_ready && pc == $past(pc) + PC_W'(2)
        ##1 issue_ready && !skip_flush)
    else $error("decrement skip wrong");

endmodule : mlr_exec

// *** sim/mlr_mem_model.sv ***
// Data memory and return stack model facing the execution datapath
`timescale 1ns/100ps

module mlr_mem_model #(
  parameter int PC_W    = 11,
  parameter int MADDR_W = 8
) (
  input  wire logic               pclk,
  input  wire logic [MADDR_W-1:0] issue_addr,
  output      logic [7:0]         mem_rdata,
  input  wire logic               mem_we,
  input  wire logic [MADDR_W-1:0] mem_waddr,
  input  wire logic [7:0]         mem_wdata,
  input  wire logic               stack_pop,
  output      logic [PC_W-1:0]    stack_pc
);
  logic [7:0]      mem [2**MADDR_W];
  logic [PC_W-1:0] top;

  // Combinational read: the byte must stand in the issue cycle
  assign mem_rdata = mem[issue_addr];
  assign stack_pc  = top;

  // A popped entry is gone, so the top turns to garbage
  always @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
    if (stack_pop) begin
      top <= ~top;
    end
  end
endmodule : mlr_mem_model

// *** sim/mlr_exec_tb_top.sv ***
// Self-checking bench for the move, logic and rotate datapath
`timescale 1ns/100ps

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  fails++; $display("mismatch %0t got %h exp %h", $time, got, exp); end end

module mlr_exec_tb_top;
  localparam logic [127:0] MEM0 = 128'h00000001_02800130_00808181_69960181;
  localparam logic [127:0] MEM1 = 128'h00008101_00807F30_8000C003_69968181;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic                issue_valid, issue_ready, mem_we, stack_pop, err;
  logic                skip_flush, gie;
  mlr_pkg::mlr_op_type issue_op;
  logic [7:0]          issue_imm, issue_addr, mem_rdata, mem_waddr;
  logic [7:0]          mem_wdata, working_reg;
  logic [10:0]         stack_pc, pc;
  logic [5:0]          status_flags;
  int                  fails, num_checks, cycles;

  mlr_exec #(.PC_W(11), .MADDR_W(8)) i_mlr_exec (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .issue_valid(issue_valid),
    .issue_op(issue_op), .issue_imm(issue_imm), .issue_addr(issue_addr),
    .mem_rdata(mem_rdata), .issue_ready(issue_ready), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .stack_pop(stack_pop),
    .stack_pc(stack_pc), .pc(pc), .skip_flush(skip_flush),
    .working_reg(working_reg), .status_flags(status_flags),
    .global_irq_enable(gie));

  mlr_mem_model #(.PC_W(11), .MADDR_W(8)) i_mlr_mem_model (
    .pclk(pclk), .issue_addr(issue_addr), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
    .stack_pop(stack_pop), .stack_pc(stack_pc));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic results();
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      results();
    end
  end

  // Ends one idle cycle after the access, so back-to-back calls stay legal
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Holds the instruction until an edge that sees issue_ready high
  task automatic exec(input mlr_pkg::mlr_op_type op,
                      input logic [7:0] imm, a);
    logic r;
    issue_valid <= 1'b1;
    issue_op <= op;
    issue_imm <= imm;
    issue_addr <= a;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge pclk);
      r = issue_ready;
      @(posedge pclk);
    end
  endtask : exec

  // Expected: wreg, flags, {we, flush, pop, ready, gie}, pc
  task automatic step(input mlr_pkg::mlr_op_type op,
                      input logic [7:0] imm, a, input logic [29:0] e);
    exec(op, imm, a);
    issue_valid <= 1'b0;
    @(negedge pclk);
    `CHK({working_reg, status_flags, mem_we, skip_flush, stack_pop,
          issue_ready, gie, pc}, e)
    @(posedge pclk);
  endtask : step

  task automatic load(input logic [10:0] v);
    @(posedge pclk);
    i_mlr_mem_model.top <= v;
  endtask : load

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    issue_valid = 1'b0;
    issue_op = mlr_pkg::OP_NOP;
    issue_imm = 8'h00;
    issue_addr = 8'h00;
    fails = 0;
    num_checks = 0;
    cycles = 0;
    for (int i = 0; i < 16; i++) begin
      i_mlr_mem_model.mem[8'h10+i] = MEM0[8*i+:8];
    end
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4*i), 32'h0);
      `CHK({err, rd}, 33'h0)
    end
    apb(1'b1, 12'h010, 32'hFF);
    apb(1'b0, 12'h010, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    step(mlr_pkg::OP_MOV_IMM, 8'h3C, 8'h00,
         {8'h3C, 6'h00, 5'h02, 11'd1});
    step(mlr_pkg::OP_NOP, 8'hFF, 8'h10,
         {8'h3C, 6'h00, 5'h02, 11'd2});
    step(mlr_pkg::OP_MOV_FROM_MEM, 8'h00, 8'h10,
         {8'h81, 6'h00, 5'h02, 11'd3});
    step(mlr_pkg::OP_MOV_IMM, 8'h00, 8'h00, {8'h00, 6'h00, 5'h02, 11'd4});
    step(mlr_pkg::OP_OR_IMM, 8'h00, 8'h00,
         {8'h00, 6'h04, 5'h02, 11'd5});
    step(mlr_pkg::OP_OR_MEM, 8'h00, 8'h10,
         {8'h81, 6'h00, 5'h02, 11'd6});
    step(mlr_pkg::OP_MOV_TO_MEM, 8'h00, 8'h1D,
         {8'h81, 6'h00, 5'h12, 11'd7});
    step(mlr_pkg::OP_OR_INTO_MEMORY, 8'h00, 8'h11,
         {8'h81, 6'h00, 5'h12, 11'd8});
    step(mlr_pkg::OP_ROT_LEFT_WREG, 8'h00, 8'h12,
         {8'h2D, 6'h00, 5'h02, 11'd9});
    step(mlr_pkg::OP_ROT_RIGHT_WREG, 8'h00, 8'h13,
         {8'hB4, 6'h00, 5'h02, 11'd10});
    step(mlr_pkg::OP_ROTATE_LEFT_THRU_CARRY_WREG, 8'h00, 8'h12,
         {8'h2C, 6'h01, 5'h02, 11'd11});
    step(mlr_pkg::OP_ROTATE_RIGHT_THRU_CARRY_WREG, 8'h00, 8'h12,
         {8'hCB, 6'h00, 5'h02, 11'd12});
    step(mlr_pkg::OP_ROT_LEFT_MEM, 8'h00, 8'h14,
         {8'hCB, 6'h00, 5'h12, 11'd13});
    step(mlr_pkg::OP_ROT_RIGHT_MEM, 8'h00, 8'h15,
         {8'hCB, 6'h00, 5'h12, 11'd14});
    step(mlr_pkg::OP_ROTATE_LEFT_THRU_CARRY, 8'h00, 8'h16,
         {8'hCB, 6'h01, 5'h12, 11'd15});
    step(mlr_pkg::OP_ROTATE_RIGHT_THRU_CARRY, 8'h00, 8'h17,
         {8'hCB, 6'h00, 5'h12, 11'd16});
    // Power-down and timeout bits set here must survive every later op
    apb(1'b1, mlr_pkg::OFS_STATUS, 32'h31);
    step(mlr_pkg::OP_MOV_IMM, 8'h50, 8'h00, {8'h50, 6'h31, 5'h02, 11'd17});
    step(mlr_pkg::OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h18,
         {8'h20, 6'h33, 5'h02, 11'd18});
    step(mlr_pkg::OP_MOV_IMM, 8'h80, 8'h00, {8'h80, 6'h33, 5'h02, 11'd19});
    step(mlr_pkg::OP_SUBTRACT_WITH_BORROW_MEM, 8'h00, 8'h19,
         {8'h80, 6'h39, 5'h12, 11'd20});
    step(mlr_pkg::OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h1A,
         {8'h00, 6'h37, 5'h02, 11'd21});
    step(mlr_pkg::OP_DECREMENT_SKIP_IF_ZERO, 8'h00, 8'h1B,
         {8'h00, 6'h37, 5'h12, 11'd22});
    step(mlr_pkg::OP_DECREMENT_SKIP_IF_ZERO, 8'h00, 8'h1B,
         {8'h00, 6'h37, 5'h18, 11'd24});
    step(mlr_pkg::OP_DECREMENT_TO_WREG_SKIP_ZERO, 8'h00, 8'h1B,
         {8'hFF, 6'h37, 5'h02, 11'd25});
    step(mlr_pkg::OP_DECREMENT_TO_WREG_SKIP_ZERO, 8'h00, 8'h1C,
         {8'h00, 6'h37, 5'h08, 11'd27});
    load(11'h123);
    step(mlr_pkg::OP_RETURN, 8'h00, 8'h00,
         {8'h00, 6'h37, 5'h04, 11'h123});
    load(11'h200);
    step(mlr_pkg::OP_RETURN_IMM, 8'h77, 8'h00,
         {8'h77, 6'h37, 5'h04, 11'h200});
    load(11'h355);
    step(mlr_pkg::OP_RETURN_FROM_IRQ, 8'h00, 8'h00,
         {8'h77, 6'h37, 5'h05, 11'h355});
    load(11'h400);
    // The second instruction waits out the dummy cycle, taken only once
    exec(mlr_pkg::OP_RETURN, 8'h00, 8'h00);
    step(mlr_pkg::OP_MOV_IMM, 8'h5A, 8'h00,
         {8'h5A, 6'h37, 5'h03, 11'h401});
    apb(1'b0, mlr_pkg::OFS_STATUS, 32'h0);
    `CHK({err, rd}, 33'h37)
    apb(1'b0, mlr_pkg::OFS_CONTROL, 32'h0);
    `CHK({err, rd}, 33'h01)
    apb(1'b1, mlr_pkg::OFS_PC, 32'h7FF);
    apb(1'b0, mlr_pkg::OFS_PC, 32'h0);
    `CHK({err, rd}, 33'h401)
    apb(1'b1, mlr_pkg::OFS_WORKING_REG, 32'hA5);
    apb(1'b0, mlr_pkg::OFS_WORKING_REG, 32'h0);
    `CHK({err, rd}, 33'hA5)
    for (int i = 0; i < 16; i++) begin
      `CHK(i_mlr_mem_model.mem[8'h10+i], MEM1[8*i+:8])
    end
    results();
  end
endmodule : mlr_exec_tb_top
